// >>> wd_watchdog_timer.sv
// Watchdog timer core: counter, sequence of prewarning and reset request
`timescale 1ns/1ps
`default_nettype none
`include "wd_defs.svh"
module wd_watchdog_timer
	import wd_pkg::*;
#(
	// Reload after reset; a value near all ones shortens simulation
	parameter logic [15:0] RELOAD_RESET_VALUE = `WD_RELOAD_RESET
)
(
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic WATCHDOG_DISABLE_CMD,
	input wire logic WATCHDOG_ENABLE_CMD,
	input wire logic WATCHDOG_SERVICE_CMD,
	input wire logic RELOAD_WRITE,
	input wire logic [15:0] RELOAD_DATA,
	input wire logic PRESCALE_WRITE,
	input wire logic PRESCALE_FAST,
	output logic WATCHDOG_ENABLED,
	output logic [15:0] WATCHDOG_COUNT,
	output logic [15:0] RELOAD_VALUE_REG,
	output logic PRESCALE_FAST_SEL,
	output logic PREWARN_IRQ,
	output logic PREWARN_ACTIVE,
	output logic RESET_REQ
);

	// ----------------------------------------
	// State and internal signals
	// ----------------------------------------
	wd_state_t st; // Registered state
	wd_state_t next_st; // Next state
	logic run; // Counter advancing
	logic tick; // Prescaled count enable
	logic service_ok; // Service taken this cycle
	logic [13:0] psc_count; // Prescaler position
	logic at_top; // Counter at all ones

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	// Counter frozen once the reset request stands
	assign run = st.enabled && (st.mode != WD_RESET);
	// Service is only honoured before the first overflow
	assign service_ok = WATCHDOG_SERVICE_CMD && (st.mode == WD_RUN);
	assign at_top = (st.count == `WD_CNT_MAX);

	// One tick per divided period
	wd_prescaler u_prescaler
	(
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.run(run),
		.clear(service_ok),
		.sel_fast(st.sel_fast),
		.tick(tick),
		.count(psc_count)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Commands, settings and the overflow sequence
	always_comb
	begin
		next_st = st;
		next_st.prewarn = 1'b0;
		// Enable wins a tie: the safer outcome
		if (WATCHDOG_ENABLE_CMD)
		begin
			next_st.enabled = 1'b1;
		end
		else if (WATCHDOG_DISABLE_CMD)
		begin
			next_st.enabled = 1'b0;
		end
		// Reload value takes effect at the next reload; the prescaler ratio at once
		if (RELOAD_WRITE)
		begin
			next_st.reload = RELOAD_DATA;
		end
		if (PRESCALE_WRITE)
		begin
			next_st.sel_fast = PRESCALE_FAST;
		end
		case (st.mode)
			WD_RUN:
			begin
				if (service_ok)
				begin
					// Reload from the programmed value
					next_st.count = st.reload;
				end
				else if (tick && at_top)
				begin
					// First overflow: warn and start the grace interval
					next_st.count = st.reload;
					next_st.prewarn = 1'b1;
					next_st.mode = WD_PREWARN;
				end
				else if (tick)
				begin
					next_st.count = st.count + `WD_CNT_ONE;
				end
			end
			WD_PREWARN:
			begin
				// Fail-safe: no service can cancel a pending reset
				if (tick && at_top)
				begin
					next_st.reset_req = 1'b1;
					next_st.mode = WD_RESET;
				end
				else if (tick)
				begin
					next_st.count = st.count + `WD_CNT_ONE;
				end
			end
			WD_RESET:
			begin
				// Held until the system reset clears it
				next_st.reset_req = 1'b1;
			end
			default:
			begin
				next_st.mode = WD_RUN;
			end
		endcase
	end

	// ----------------------------------------
	// Register
	// ----------------------------------------
	// Reset leaves the watchdog running with default interval
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			st.mode <= WD_RUN;
			st.enabled <= 1'b1;
			st.count <= RELOAD_RESET_VALUE;
			st.reload <= RELOAD_RESET_VALUE;
			st.sel_fast <= `WD_SEL_RESET;
			st.prewarn <= 1'b0;
			st.reset_req <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from state
	// ----------------------------------------
	assign WATCHDOG_ENABLED = st.enabled;
	assign WATCHDOG_COUNT = st.count;
	assign RELOAD_VALUE_REG = st.reload;
	assign PRESCALE_FAST_SEL = st.sel_fast;
	assign PREWARN_IRQ = st.prewarn;
	// One state bit, so the pin needs no decode gate
	assign PREWARN_ACTIVE = st.mode[`WD_MODE_PREWARN_BIT];
	assign RESET_REQ = st.reset_req;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// A plain count step with no wrap and no service
	sequence s_plain_tick;
		tick && run && !at_top && !service_ok;
	endsequence

	// First overflow while still in normal running
	sequence s_first_ovf;
		(st.mode == WD_RUN) && tick && at_top && !service_ok;
	endsequence

	// Second overflow, in the grace interval
	sequence s_second_ovf;
		(st.mode == WD_PREWARN) && tick && at_top;
	endsequence

	property p_enable_after_reset;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$past(SYS_RST) |-> (WATCHDOG_ENABLED && !RESET_REQ && !PREWARN_ACTIVE);
	endproperty
	a_enable_after_reset: assert property (p_enable_after_reset)
		else $error("watchdog not enabled after reset");

	property p_enable_cmd;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		WATCHDOG_ENABLE_CMD |=> WATCHDOG_ENABLED;
	endproperty
	a_enable_cmd: assert property (p_enable_cmd)
		else $error("enable command did not enable");

	property p_disable_cmd;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		(WATCHDOG_DISABLE_CMD && !WATCHDOG_ENABLE_CMD) |=> !WATCHDOG_ENABLED ##1
		(WATCHDOG_COUNT == $past(WATCHDOG_COUNT) || $past(service_ok)
		|| $past(WATCHDOG_ENABLE_CMD));
	endproperty
	a_disable_cmd: assert property (p_disable_cmd)
		else $error("disabled watchdog kept counting");

	property p_prewarn_first;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		s_first_ovf |=> (PREWARN_IRQ && !RESET_REQ) ##1 !PREWARN_IRQ;
	endproperty
	a_prewarn_first: assert property (p_prewarn_first)
		else $error("overflow did not give a single prewarning pulse");

	property p_reset_after_prewarn;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$rose(RESET_REQ) |-> ($past(st.mode) == WD_PREWARN) && !PREWARN_IRQ;
	endproperty
	a_reset_after_prewarn: assert property (p_reset_after_prewarn)
		else $error("reset request without prior prewarning");

	property p_count_step;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		s_plain_tick |=> (WATCHDOG_COUNT == $past(WATCHDOG_COUNT) + `WD_CNT_ONE);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not step by one on a tick");

	property p_tick_ratio;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		tick |-> (psc_count == (st.sel_fast ? `WD_PSC_TOP_FAST : `WD_PSC_TOP_SLOW));
	endproperty
	a_tick_ratio: assert property (p_tick_ratio)
		else $error("tick off the selected division ratio");

	property p_service_reload;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		service_ok |=> (WATCHDOG_COUNT == $past(st.reload)) && (psc_count == `WD_PSC_ZERO);
	endproperty
	a_service_reload: assert property (p_service_reload)
		else $error("service did not reload counter and clear prescaler");

	property p_reset_defaults;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$past(SYS_RST) |-> (RELOAD_VALUE_REG == RELOAD_RESET_VALUE)
		&& (WATCHDOG_COUNT == RELOAD_RESET_VALUE) && (PRESCALE_FAST_SEL == `WD_SEL_RESET);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("reset defaults wrong");

	property p_wrap_reload;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		s_first_ovf |=> (WATCHDOG_COUNT == $past(st.reload)) && PREWARN_ACTIVE;
	endproperty
	a_wrap_reload: assert property (p_wrap_reload)
		else $error("wrap did not reload the counter");

	property p_second_wrap;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		s_second_ovf |=> RESET_REQ [*2];
	endproperty
	a_second_wrap: assert property (p_second_wrap)
		else $error("second wrap did not hold reset request");

endmodule
`default_nettype wire

// >>> wd_defs.svh
// Constants for the watchdog timer block
// Contract
// - Watchdog runs automatically after application reset
// - Disable and enable commands accepted any time
// - Overflow raises prewarning, then reset request
// - Watchdog count is a 16-bit counter
// - Prescaler divides system clock by two ratios
// - Service reloads counter and clears prescaler before the first overflow
// - Reset defaults give 6.5 ms at 10 MHz
`ifndef WD_DEFS_SVH
`define WD_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define WD_CNT_W 16
`define WD_PSC_W 14

// ----------------------------------------
// Counter and prescaler values
// ----------------------------------------
`define WD_CNT_MAX 16'hFFFF
`define WD_CNT_ONE 16'h0001
`define WD_PSC_ZERO 14'h0000
`define WD_PSC_ONE 14'h0001
`define WD_PSC_TOP_SLOW 14'h3FFF
`define WD_PSC_TOP_FAST 14'h00FF
`define WD_DIV_FAST 256
`define WD_SEL_RESET 1'b1
// Only the prewarning state has this bit of the state code set
`define WD_MODE_PREWARN_BIT 0

// ----------------------------------------
// Timing of the power-up interval
// ----------------------------------------
`define WD_CLK_PERIOD_NS 100
`define WD_DEFAULT_INTERVAL_NS 6500000
`define WD_DEFAULT_CYCLES (`WD_DEFAULT_INTERVAL_NS / `WD_CLK_PERIOD_NS)
`define WD_DEFAULT_TICKS ((`WD_DEFAULT_CYCLES + `WD_DIV_FAST - 1) / `WD_DIV_FAST)
`define WD_RELOAD_RESET (16'(32'h00010000 - (`WD_DEFAULT_TICKS)))

`endif

// >>> wd_pkg.sv
// Types shared by the watchdog timer modules
`default_nettype none
package wd_pkg;

	// Watchdog sequence state
	typedef enum logic [1:0]
	{
		WD_RUN = 2'b00,
		WD_PREWARN = 2'b01,
		WD_RESET = 2'b10
	} wd_mode_t;

	// Whole state of the watchdog core
	typedef struct packed
	{
		wd_mode_t mode;
		logic enabled;
		logic [15:0] count;
		logic [15:0] reload;
		logic sel_fast;
		logic prewarn;
		logic reset_req;
	} wd_state_t;

	// Whole state of the prescaler
	typedef struct packed
	{
		logic [13:0] count;
	} wd_psc_state_t;

endpackage
`default_nettype wire

// >>> wd_prescaler.sv
// Prescaler that turns the system clock into watchdog count ticks
`timescale 1ns/1ps
`default_nettype none
`include "wd_defs.svh"
module wd_prescaler
	import wd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic clear,
	input wire logic sel_fast,
	output logic tick,
	output logic [13:0] count
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	wd_psc_state_t st; // Registered state
	wd_psc_state_t next_st; // Next state
	logic [13:0] top; // Terminal count for the chosen ratio

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Tick only while running, on the terminal count
	always_comb
	begin
		top = sel_fast ? `WD_PSC_TOP_FAST : `WD_PSC_TOP_SLOW;
		tick = run && (st.count == top);
		next_st = st;
		if (clear)
		begin
			// Service restarts a full prescaler period
			next_st.count = `WD_PSC_ZERO;
		end
		else if (tick)
		begin
			next_st.count = `WD_PSC_ZERO;
		end
		else if (run)
		begin
			// Above top after a ratio change: wraps through all ones once
			next_st.count = st.count + `WD_PSC_ONE;
		end
	end

	// Register
	always_ff @(posedge clk)
	begin
		if (rst)
			st <= '{count: `WD_PSC_ZERO};
		else
			st <= next_st;
	end

	assign count = st.count;

endmodule
`default_nettype wire

// >>> wd_watchdog_timer_test.sv
// Self-checking bench for the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
module wd_watchdog_timer_test
	import wd_pkg::*;
;
	// ------------------------------
	// Stimulus and observed signals
	// ------------------------------
	localparam logic [15:0] RST_RELOAD = 16'hFFFE; // Short reload keeps runs brief
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic dis_cmd = 1'b0;
	logic en_cmd = 1'b0;
	logic svc_cmd = 1'b0;
	logic rel_wr = 1'b0;
	logic [15:0] rel_data = 16'h0000;
	logic psc_wr = 1'b0;
	logic psc_fast = 1'b0;
	logic enabled, irq, pw_act, rst_req, fast_sel;
	logic [15:0] count, reload;
	logic [15:0] held; // Snapshot of the counter
	int bad_count = 0;
	int n_tests = 0;
	int n; // Measured cycles

	wd_watchdog_timer #(.RELOAD_RESET_VALUE(RST_RELOAD)) DUT (.CLK_SYS(clk_sys),
		.SYS_RST(sys_rst), .WATCHDOG_DISABLE_CMD(dis_cmd), .WATCHDOG_ENABLE_CMD(en_cmd),
		.WATCHDOG_SERVICE_CMD(svc_cmd), .RELOAD_WRITE(rel_wr), .RELOAD_DATA(rel_data),
		.PRESCALE_WRITE(psc_wr), .PRESCALE_FAST(psc_fast), .WATCHDOG_ENABLED(enabled),
		.WATCHDOG_COUNT(count), .RELOAD_VALUE_REG(reload), .PRESCALE_FAST_SEL(fast_sel),
		.PREWARN_IRQ(irq), .PREWARN_ACTIVE(pw_act), .RESET_REQ(rst_req));

	// 10 MHz system clock
	always #50 clk_sys = ~clk_sys;

	// ------------------------------
	// Shared tasks
	// ------------------------------
	// Step edges; inputs change 1 ns after each edge
	task automatic tk(input int k);
		repeat (k)
		begin
			@(posedge clk_sys);
			#1;
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Service is one cycle; counter shows reload after it
	task automatic svc();
		svc_cmd = 1'b1;
		tk(1);
		svc_cmd = 1'b0;
	endtask

	// Edges until the counter moves, bounded
	task automatic gap(output int m);
		held = count;
		m = 0;
		while (count === held && m < 20000)
		begin
			tk(1);
			m++;
		end
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_reset();
		tk(6);
		chk_word("reload", RST_RELOAD, reload);
		chk_bit("fast_sel", 1'b1, fast_sel);
		sys_rst = 1'b0;
		tk(1);
		chk_bit("enabled", 1'b1, enabled);
		chk_word("count", RST_RELOAD, count);
		chk_bit("rst_req", 1'b0, rst_req);
	endtask

	// Tick spacing from a service, mid-interval service clears prescaler
	task automatic t_tick();
		svc();
		gap(n);
		chk_word("fast gap", 16'(256), 16'(n));
		chk_word("count up", RST_RELOAD + 16'h0001, count);
		tk(100);
		svc();
		chk_word("service", RST_RELOAD, count);
		gap(n);
		chk_word("gap after svc", 16'(256), 16'(n));
	endtask

	// Slow ratio, then back to fast
	task automatic t_slow();
		psc_wr = 1'b1;
		psc_fast = 1'b0;
		tk(1);
		psc_wr = 1'b0;
		chk_bit("fast_sel", 1'b0, fast_sel);
		svc();
		gap(n);
		chk_word("slow gap", 16'(16384), 16'(n));
		psc_wr = 1'b1;
		psc_fast = 1'b1;
		tk(1);
		psc_wr = 1'b0;
	endtask

	// New reload taken at service; full 16-bit word
	task automatic t_reload(input logic [15:0] v);
		rel_wr = 1'b1;
		rel_data = v;
		tk(1);
		rel_wr = 1'b0;
		chk_word("reload reg", v, reload);
		svc();
		chk_word("loaded", v, count);
		gap(n);
		chk_word("loaded gap", 16'(256), 16'(n));
		chk_word("loaded up", v + 16'h0001, count);
	endtask

	// Disable freezes; enable wins when both arrive together
	task automatic t_cmd();
		dis_cmd = 1'b1;
		tk(1);
		dis_cmd = 1'b0;
		chk_bit("disabled", 1'b0, enabled);
		held = count;
		tk(600);
		chk_word("frozen", held, count);
		en_cmd = 1'b1;
		tk(1);
		en_cmd = 1'b0;
		chk_bit("re-enabled", 1'b1, enabled);
		// Tie: enable must win, so the watchdog stays on
		dis_cmd = 1'b1;
		en_cmd = 1'b1;
		tk(1);
		dis_cmd = 1'b0;
		en_cmd = 1'b0;
		chk_bit("tie enabled", 1'b1, enabled);
		svc();
		gap(n);
		chk_word("resumed gap", 16'(256), 16'(n));
	endtask

	// Unserviced overflow: prewarning pulse, refused service, reset request
	task automatic t_ovf();
		svc();
		n = 0;
		while (irq !== 1'b1 && n < 2000)
		begin
			tk(1);
			n++;
		end
		chk_word("irq delay", 16'(512), 16'(n));
		chk_word("ovf reload", RST_RELOAD, count);
		chk_bit("rst early", 1'b0, rst_req);
		svc();
		chk_bit("irq pulse", 1'b0, irq);
		chk_bit("prewarn", 1'b1, pw_act);
		// A taken service would clear the prescaler and delay this step
		tk(255);
		chk_word("svc refused", RST_RELOAD + 16'h0001, count);
		n = 256;
		while (rst_req !== 1'b1 && n < 2000)
		begin
			tk(1);
			n++;
		end
		chk_word("rst delay", 16'(512), 16'(n));
		tk(300);
		chk_bit("rst held", 1'b1, rst_req);
		sys_rst = 1'b1;
		tk(2);
		sys_rst = 1'b0;
		tk(1);
		chk_bit("rst cleared", 1'b0, rst_req);
		chk_bit("enabled again", 1'b1, enabled);
	endtask

	// ------------------------------
	// Verdict and sequencing
	// ------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence; overflow last since it ends in a reset request
	initial
	begin
		t_reset();
		t_tick();
		t_slow();
		t_reload(16'h1234);
		t_reload(RST_RELOAD);
		t_cmd();
		t_ovf();
		summarize();
	end

	// Hang guard, well beyond the roughly 20k cycles expected
	initial
	begin
		#(100 * 40000);
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire
